// ---- rtl/ttm_top.sv ----
// tape transport motor control with apb register port
// assumes apb master on pclk; switch and reel pulse pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

module ttm_top #(
    parameter int CNT_W      = 16,
    parameter int DEAD_TICKS = ttm_pkg::DEAD_TICKS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        head_position_switch,
    input  wire logic        reel_counter_pulse,
    output logic             fast_fwd_source_n,
    output logic             forward_return,
    output logic             rewind_source,
    output logic             rewind_return_n,
    output logic             play_servo_disable,
    output logic             head_motor_on,
    output logic             head_brake_n,
    output logic             irq
);

    generate
        if (CNT_W < 1 || CNT_W > 32 || DEAD_TICKS < 1) begin : g_chk
            $error("ttm_top: bad CNT_W or DEAD_TICKS");
        end
    endgenerate

    localparam int DW = $clog2(DEAD_TICKS + 1);

    // ==================================================================
    // pin synchronisers and divider
    logic [1:0] pins_s;
    logic       sw_closed;
    logic       reel_s;
    logic       tick;

    ttm_sync #(
        .W        (2)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({reel_counter_pulse, head_position_switch}),
        .sync_out (pins_s)
    );

    assign sw_closed = pins_s[0];
    assign reel_s    = pins_s[1];

    ttm_tick #(
        .DIV     (ttm_pkg::TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // ==================================================================
    // apb decode
    logic setup_ph;
    logic wr_acc;
    logic mapped;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign mapped   = is_reg(paddr, ttm_pkg::OFS_CTRL)
                   || is_reg(paddr, ttm_pkg::OFS_HEAD)
                   || is_reg(paddr, ttm_pkg::OFS_STATUS)
                   || is_reg(paddr, ttm_pkg::OFS_COUNT)
                   || is_reg(paddr, ttm_pkg::OFS_IRQ_STAT)
                   || is_reg(paddr, ttm_pkg::OFS_IRQ_MASK);
    // zero wait states: every access completes in its first access cycle
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;

    logic wr_ctrl;
    logic wr_head;
    logic wr_count;
    logic wr_istat;
    logic wr_imask;

    assign wr_ctrl  = wr_acc && is_reg(paddr, ttm_pkg::OFS_CTRL);
    assign wr_head  = wr_acc && is_reg(paddr, ttm_pkg::OFS_HEAD);
    assign wr_count = wr_acc && is_reg(paddr, ttm_pkg::OFS_COUNT);
    assign wr_istat = wr_acc && is_reg(paddr, ttm_pkg::OFS_IRQ_STAT);
    assign wr_imask = wr_acc && is_reg(paddr, ttm_pkg::OFS_IRQ_MASK);

    // ==================================================================
    // software registers
    ttm_pkg::ttm_cmd_t     cmd_q;
    logic [ttm_pkg::EV_W-1:0] mask_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= ttm_pkg::ttm_cmd_t'(ttm_pkg::CTRL_RST);
        end else if (wr_ctrl) begin
            cmd_q <= ttm_pkg::ttm_cmd_t'(pwdata[1:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= ttm_pkg::MASK_RST;
        end else if (wr_imask) begin
            mask_q <= pwdata[ttm_pkg::EV_W-1:0];
        end
    end

    // ==================================================================
    // tape motor sequencer
    ttm_pkg::ttm_motor_t motor_q;
    ttm_pkg::ttm_motor_t motor_d;
    logic [DW-1:0]       dead_q;
    ttm_pkg::ttm_motor_t target;
    ttm_pkg::ttm_bridge_t bridge_q;
    ttm_pkg::ttm_bridge_t bridge_d;

    always_comb begin
        case (cmd_q)
            ttm_pkg::CMD_PLAY:   target = ttm_pkg::M_PLAY;
            ttm_pkg::CMD_FAST:   target = ttm_pkg::M_FAST;
            ttm_pkg::CMD_REWIND: target = ttm_pkg::M_REWIND;
            default:             target = ttm_pkg::M_STOP;
        endcase
    end

    always_comb begin
        motor_d = motor_q;
        case (motor_q)
            ttm_pkg::M_STOP: begin
                motor_d = target;
            end
            ttm_pkg::M_PLAY,
            ttm_pkg::M_FAST,
            ttm_pkg::M_REWIND: begin
                // any change of drive goes through all-off first
                if (target == ttm_pkg::M_STOP) begin
                    motor_d = ttm_pkg::M_STOP;
                end else if (target != motor_q) begin
                    motor_d = ttm_pkg::M_DEAD;
                end
            end
            ttm_pkg::M_DEAD: begin
                if (dead_q == '0) begin
                    motor_d = target;
                end
            end
            default: motor_d = ttm_pkg::M_STOP;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_q <= ttm_pkg::M_STOP;
        end else begin
            motor_q <= motor_d;
        end
    end

    // dead time counted in 1 us ticks; reloaded on entry to all-off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dead_q <= '0;
        end else if (motor_d == ttm_pkg::M_DEAD
                     && motor_q != ttm_pkg::M_DEAD) begin
            dead_q <= DW'(DEAD_TICKS);
        end else if (tick && dead_q != '0) begin
            dead_q <= dead_q - 1'b1;
        end
    end

    always_comb begin
        bridge_d = ttm_pkg::BRIDGE_OFF;
        case (motor_d)
            ttm_pkg::M_FAST: begin
                bridge_d.fast_fwd_source_n  = 1'b0;
                bridge_d.forward_return     = 1'b1;
                bridge_d.play_servo_disable = 1'b1;
            end
            ttm_pkg::M_REWIND: begin
                bridge_d.rewind_source      = 1'b1;
                bridge_d.rewind_return_n    = 1'b0;
                bridge_d.play_servo_disable = 1'b1;
            end
            ttm_pkg::M_PLAY: begin
                // servo owns the source transistor, so its line stays off
                bridge_d.forward_return     = 1'b1;
                bridge_d.play_servo_disable = 1'b0;
            end
            default: bridge_d = ttm_pkg::BRIDGE_OFF;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_q <= ttm_pkg::BRIDGE_OFF;
        end else begin
            bridge_q <= bridge_d;
        end
    end

    assign fast_fwd_source_n  = bridge_q.fast_fwd_source_n;
    assign forward_return     = bridge_q.forward_return;
    assign rewind_source      = bridge_q.rewind_source;
    assign rewind_return_n    = bridge_q.rewind_return_n;
    assign play_servo_disable = bridge_q.play_servo_disable;

    // ==================================================================
    // head motor: switch opens at loaded end, closes at unloaded end
    ttm_pkg::ttm_head_t head_q;
    ttm_pkg::ttm_head_t head_d;
    logic load_req;
    logic unload_req;
    logic ev_loaded;
    logic ev_unloaded;

    assign load_req   = wr_head && pwdata[ttm_pkg::HEAD_LOAD_BIT];
    assign unload_req = wr_head && pwdata[ttm_pkg::HEAD_UNLOAD_BIT];

    always_comb begin
        head_d = head_q;
        case (head_q)
            ttm_pkg::H_IDLE: begin
                // a command already satisfied by the switch is ignored
                if (load_req && sw_closed) begin
                    head_d = ttm_pkg::H_LOAD;
                end else if (unload_req && !sw_closed) begin
                    head_d = ttm_pkg::H_UNLOAD;
                end
            end
            ttm_pkg::H_LOAD: begin
                if (!sw_closed) begin
                    head_d = ttm_pkg::H_IDLE;
                end
            end
            ttm_pkg::H_UNLOAD: begin
                if (sw_closed) begin
                    head_d = ttm_pkg::H_IDLE;
                end
            end
            default: head_d = ttm_pkg::H_IDLE;
        endcase
    end

    assign ev_loaded   = head_q == ttm_pkg::H_LOAD && !sw_closed;
    assign ev_unloaded = head_q == ttm_pkg::H_UNLOAD && sw_closed;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            head_q        <= ttm_pkg::H_IDLE;
            head_motor_on <= 1'b0;
            head_brake_n  <= 1'b1;
        end else begin
            head_q        <= head_d;
            // one on/off line for both travel directions
            head_motor_on <= head_d != ttm_pkg::H_IDLE;
            // brake released from reset and while running, applied when a move ends at the switch
            if (head_d != ttm_pkg::H_IDLE) begin
                head_brake_n <= 1'b1;
            end else if (ev_loaded || ev_unloaded) begin
                head_brake_n <= 1'b0;
            end
        end
    end

    // ==================================================================
    // reel counter; the same pulse reaches the processor nmi off-chip
    logic             reel_d1_q;
    logic             reel_rise;
    logic [CNT_W-1:0] count_q;

    assign reel_rise = reel_s && !reel_d1_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reel_d1_q <= 1'b0;
            count_q   <= '0;
        end else begin
            reel_d1_q <= reel_s;
            if (wr_count) begin
                count_q <= CNT_W'(reel_rise);
            end else if (reel_rise) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // ==================================================================
    // interrupts: sticky, write one to clear, set wins over clear
    logic [ttm_pkg::EV_W-1:0] istat_q;
    logic [ttm_pkg::EV_W-1:0] ev;
    logic [ttm_pkg::EV_W-1:0] clr;

    always_comb begin
        ev = '0;
        ev[ttm_pkg::EV_MODE]     = motor_d != motor_q
                                   && motor_d != ttm_pkg::M_DEAD;
        ev[ttm_pkg::EV_LOADED]   = ev_loaded;
        ev[ttm_pkg::EV_UNLOADED] = ev_unloaded;
        ev[ttm_pkg::EV_REEL]     = reel_rise;
    end

    assign clr = wr_istat ? pwdata[ttm_pkg::EV_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= '0;
            irq     <= 1'b0;
        end else begin
            istat_q <= (istat_q & ~clr) | ev;
            irq     <= |(((istat_q & ~clr) | ev) & mask_q);
        end
    end

    // ==================================================================
    // read data captured in the setup cycle
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = '0;
        case (paddr)
            ttm_pkg::OFS_CTRL:     rdata_d[1:0] = cmd_q;
            ttm_pkg::OFS_STATUS: begin
                rdata_d[ttm_pkg::ST_MOTOR_LSB +: 5] = motor_q;
                rdata_d[ttm_pkg::ST_HEAD_LSB +: 3]  = head_q;
                rdata_d[ttm_pkg::ST_SW_BIT]         = sw_closed;
            end
            ttm_pkg::OFS_COUNT:    rdata_d[CNT_W-1:0] = count_q;
            ttm_pkg::OFS_IRQ_STAT: rdata_d[ttm_pkg::EV_W-1:0] = istat_q;
            ttm_pkg::OFS_IRQ_MASK: rdata_d[ttm_pkg::EV_W-1:0] = mask_q;
            default:               rdata_d = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_ph && !pwrite) begin
            prdata <= rdata_d;
        end
    end

endmodule // ttm_top

`default_nettype wire

// ---- rtl/ttm_pkg.sv ----
// tape transport motor control: shared constants and types
// assumes a 100 MHz pclk and a 32-bit apb register port
package ttm_pkg;

    // ==================================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int DEAD_TIME_US  = 10;
    localparam int DEAD_TICKS    = (DEAD_TIME_US * 1000) / TICK_NS;

    // ==================================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_HEAD     = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_COUNT    = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // head command bits
    localparam int HEAD_LOAD_BIT   = 0;
    localparam int HEAD_UNLOAD_BIT = 1;

    // event bits in irq status and mask
    localparam int EV_MODE     = 0;
    localparam int EV_LOADED   = 1;
    localparam int EV_UNLOADED = 2;
    localparam int EV_REEL     = 3;
    localparam int EV_W        = 4;

    // status field positions
    localparam int ST_MOTOR_LSB = 0;
    localparam int ST_HEAD_LSB  = 5;
    localparam int ST_SW_BIT    = 8;

    // reset values
    localparam logic [1:0]      CTRL_RST = 2'h0;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;

    // ==================================================================
    // software mode commands
    typedef enum logic [1:0] {
        CMD_STOP   = 2'h0,
        CMD_PLAY   = 2'h1,
        CMD_FAST   = 2'h2,
        CMD_REWIND = 2'h3
    } ttm_cmd_t;

    typedef enum logic [4:0] {
        M_STOP   = 5'h01,
        M_PLAY   = 5'h02,
        M_FAST   = 5'h04,
        M_REWIND = 5'h08,
        M_DEAD   = 5'h10
    } ttm_motor_t;

    typedef enum logic [2:0] {
        H_IDLE   = 3'h1,
        H_LOAD   = 3'h2,
        H_UNLOAD = 3'h4
    } ttm_head_t;

    // tape motor h-bridge and servo drive lines
    typedef struct packed {
        logic fast_fwd_source_n;
        logic forward_return;
        logic rewind_source;
        logic rewind_return_n;
        logic play_servo_disable;
    } ttm_bridge_t;

    localparam ttm_bridge_t BRIDGE_OFF = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

endpackage : ttm_pkg

// ---- rtl/ttm_sync.sv ----
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous levels; the first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module ttm_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    generate
        if (W < 1) begin : g_chk
            $error("ttm_sync: W must be at least 1");
        end
    endgenerate

    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // ttm_sync

`default_nettype wire

// ---- rtl/ttm_tick.sv ----
// divider: one-cycle enable pulse every DIV clocks
// assumes a single free-running pclk
`timescale 1ns/1ps
`default_nettype none

module ttm_tick #(
    parameter int DIV = 100
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);

    generate
        if (DIV < 2) begin : g_chk
            $error("ttm_tick: DIV must be at least 2");
        end
    endgenerate

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            tick  <= (cnt_q == LAST);
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end

endmodule // ttm_tick

`default_nettype wire

// ---- bench/ttm_properties.sv ----
// checker for ttm_top: bridge, servo and head motor output relations
// assumes it is bound into ttm_top and sees only the top module's ports
`timescale 1ns/1ps
`default_nettype none

module ttm_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        head_position_switch,
    input wire logic        fast_fwd_source_n,
    input wire logic        forward_return,
    input wire logic        rewind_source,
    input wire logic        rewind_return_n,
    input wire logic        play_servo_disable,
    input wire logic        head_motor_on,
    input wire logic        head_brake_n
);
    // ==================================================================
    // helpers
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic all_off;
    logic stop_wr;
    assign all_off = fast_fwd_source_n && !forward_return && !rewind_source
                     && rewind_return_n && !play_servo_disable;
    assign stop_wr = psel && penable && pwrite && paddr == ttm_pkg::OFS_CTRL
                     && pwdata[1:0] == ttm_pkg::CMD_STOP;
    // ==================================================================
    // tape motor bridge
    property p_fast;
        !fast_fwd_source_n |-> forward_return && !rewind_source
            && rewind_return_n && play_servo_disable;
    endproperty
    a_fast: assert property (p_fast) else $error("fast forward drive");
    property p_rewind;
        !rewind_return_n |-> rewind_source && fast_fwd_source_n
            && !forward_return && play_servo_disable;
    endproperty
    a_rewind: assert property (p_rewind) else $error("rewind drive");
    property p_servo;
        play_servo_disable |-> !fast_fwd_source_n || rewind_source;
    endproperty
    a_servo: assert property (p_servo) else $error("servo off");
    property p_play;
        forward_return && fast_fwd_source_n |-> !play_servo_disable
            && !rewind_source && rewind_return_n;
    endproperty
    a_play: assert property (p_play) else $error("play drive");
    // stop lands one edge after the write edge, checked two edges later
    property p_stop;
        stop_wr |-> ##3 all_off;
    endproperty
    a_stop: assert property (p_stop) else $error("stop drive");
    property p_dead;
        $rose(rewind_source) || $fell(fast_fwd_source_n) |-> $past(all_off);
    endproperty
    a_dead: assert property (p_dead) else $error("no dead gap");
    // ==================================================================
    // head motor
    property p_brake;
        $fell(head_motor_on) |-> !head_brake_n;
    endproperty
    a_brake: assert property (p_brake) else $error("no brake");
    property p_run;
        head_motor_on && $past(head_motor_on) |-> head_brake_n;
    endproperty
    a_run: assert property (p_run) else $error("brake on run");
    // two synchroniser stages plus the stopping edge
    property p_until;
        $changed(head_position_switch) && head_motor_on
            |-> ##[1:4] !head_motor_on;
    endproperty
    a_until: assert property (p_until) else $error("head overrun");
endmodule // ttm_properties

bind ttm_top ttm_properties u_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .head_position_switch, .fast_fwd_source_n, .forward_return,
    .rewind_source, .rewind_return_n, .play_servo_disable,
    .head_motor_on, .head_brake_n
);
`default_nettype wire

// ---- bench/ttm_head_mech.sv ----
// head carriage model: one-way motor turns a cam, switch on the carriage
// assumes head motor and brake lines from ttm_top; travel set by the bench
`timescale 1ns/1ps
`default_nettype none

module ttm_head_mech (
    input  wire logic       pclk,
    input  wire logic       head_motor_on,
    input  wire logic       head_brake_n,
    input  wire logic [7:0] travel,
    output logic            head_position_switch
);
    // ==================================================================
    // carriage position, one step per clock while driven
    int pos = 0;
    // the cam only goes round; a braked motor does not coast
    always @(posedge pclk) begin
        if (head_motor_on && head_brake_n) begin
            pos <= (pos + 1 >= 2 * int'(travel)) ? 0 : pos + 1;
        end
    end
    // closed from the unloaded end, open from the loaded position on
    assign head_position_switch = (pos < int'(travel));
endmodule // ttm_head_mech
`default_nettype wire

// ---- bench/ttm_top_test.sv ----
// self-checking bench for ttm_top: apb master, head carriage, reel pulses
// assumes ttm_pkg, ttm_top, the checker and ttm_head_mech compiled first
`timescale 1ns/1ps
`default_nettype none

module ttm_top_test;
    // ==================================================================
    // signals
    localparam int          DEAD = 2;
    localparam logic [23:0] SEQ  = 24'hb4f278;
    logic                 pclk;
    logic                 presetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [7:0]           paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 sw;
    logic                 reel;
    logic                 hm_on;
    logic                 brk_n;
    logic                 irq;
    logic                 mmask;
    logic [7:0]           travel;
    logic [31:0]          rd;
    logic                 err;
    ttm_pkg::ttm_bridge_t br;
    int                   n;
    int                   fails     = 0;
    int                   cmp_count = 0;
    ttm_pkg::ttm_cmd_t    cur       = ttm_pkg::CMD_STOP;
    // ==================================================================
    // design and head carriage
    ttm_top #(.CNT_W(16), .DEAD_TICKS(DEAD)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .head_position_switch(sw),
        .reel_counter_pulse(reel), .head_motor_on(hm_on),
        .fast_fwd_source_n(br.fast_fwd_source_n),
        .forward_return(br.forward_return),
        .rewind_source(br.rewind_source),
        .rewind_return_n(br.rewind_return_n),
        .play_servo_disable(br.play_servo_disable),
        .head_brake_n(brk_n), .irq(irq)
    );
    ttm_head_mech u_mech (
        .pclk(pclk), .head_motor_on(hm_on), .head_brake_n(brk_n),
        .travel(travel), .head_position_switch(sw)
    );
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    // ==================================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    // entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // msb first: source_n, forward return, rewind source, return_n, servo off
    function automatic ttm_pkg::ttm_bridge_t exp_br(ttm_pkg::ttm_cmd_t c);
        case (c)
            ttm_pkg::CMD_FAST:   return ttm_pkg::ttm_bridge_t'(5'h0b);
            ttm_pkg::CMD_REWIND: return ttm_pkg::ttm_bridge_t'(5'h15);
            ttm_pkg::CMD_PLAY:   return ttm_pkg::ttm_bridge_t'(5'h1a);
            default:             return ttm_pkg::ttm_bridge_t'(5'h12);
        endcase
    endfunction
    task automatic set_mode(input ttm_pkg::ttm_cmd_t c);
        logic [4:0] m;
        int         k;
        m = 5'h01 << c;
        apb(1'h1, ttm_pkg::OFS_CTRL, {30'h0, c});
        for (k = 0; k < 100 && (k == 0 || rd[4:0] !== m); k++)
            apb(1'h0, ttm_pkg::OFS_STATUS, 32'h0);
        chk(rd[4:0], m, "motor state");
        chk(br, exp_br(c), "bridge lines");
        chk(irq, mmask && c != cur, "mode irq");
        apb(1'h1, ttm_pkg::OFS_IRQ_STAT, 32'h1);
        chk(irq, 1'h0, "irq after clear");
        cur = c;
    endtask
    task automatic head(input int b, input logic exp_sw);
        int k;
        apb(1'h1, ttm_pkg::OFS_HEAD, 32'h1 << b);
        for (k = 0; k < 8 && hm_on !== 1'h1; k++) @(posedge pclk);
        chk(hm_on, 1'h1, "head motor start");
        for (k = 0; k < 600 && hm_on !== 1'h0; k++) @(posedge pclk);
        chk({sw, brk_n}, {exp_sw, 1'h0}, "head stop");
        apb(1'h0, ttm_pkg::OFS_STATUS, 32'h0);
        chk(rd[8:5], {exp_sw, 3'h1}, "head status");
        apb(1'h0, ttm_pkg::OFS_IRQ_STAT, 32'h0);
        chk(rd[ttm_pkg::EV_LOADED + b], 1'h1, "head event");
        apb(1'h1, ttm_pkg::OFS_IRQ_STAT, 32'h1 << (ttm_pkg::EV_LOADED + b));
        apb(1'h1, ttm_pkg::OFS_HEAD, 32'h1 << b);
        repeat (4) @(posedge pclk);
        chk(hm_on, 1'h0, "head run refused");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==================================================================
    // tests
    initial begin
        repeat (50000) @(posedge pclk);
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        void'($urandom(77223));
        {presetn, psel, penable, pwrite, reel, mmask, paddr, pwdata} = '0;
        travel = 8'h10;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk(br, exp_br(ttm_pkg::CMD_STOP), "bridge at reset");
        chk({hm_on, brk_n, irq}, 3'h2, "head at reset");
        apb(1'h0, ttm_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'(ttm_pkg::CTRL_RST), "ctrl reset value");
        chk(err, 1'h0, "mapped access error");
        apb(1'h1, 8'h1c, 32'h3);
        chk(err, 1'h1, "unmapped write");
        apb(1'h0, 8'h1c, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            mmask = p[0];
            apb(1'h1, ttm_pkg::OFS_IRQ_MASK, 32'(p) << ttm_pkg::EV_MODE);
            for (int i = 0; i < 18; i++) begin
                set_mode(i < 12 ? ttm_pkg::ttm_cmd_t'(SEQ[2*i +: 2])
                                : ttm_pkg::ttm_cmd_t'(2'($urandom)));
            end
        end
        $display("test modes done");
        for (int h = 0; h < 3; h++) begin
            travel <= 8'h08 + 8'($urandom % 33);
            @(posedge pclk);
            head(ttm_pkg::HEAD_LOAD_BIT, 1'h0);
            head(ttm_pkg::HEAD_UNLOAD_BIT, 1'h1);
        end
        $display("test head done");
        apb(1'h1, ttm_pkg::OFS_COUNT, 32'h0);
        n = 3 + $urandom % 10;
        for (int i = 0; i < n; i++) begin
            reel <= 1'h1;
            repeat (2 + $urandom % 6) @(posedge pclk);
            reel <= 1'h0;
            repeat (2 + $urandom % 6) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        apb(1'h0, ttm_pkg::OFS_COUNT, 32'h0);
        chk(rd, 32'(n), "reel count");
        apb(1'h0, ttm_pkg::OFS_IRQ_STAT, 32'h0);
        chk(rd[ttm_pkg::EV_REEL], 1'h1, "reel event");
        $display("test reel done");
        stop_test();
    end
endmodule // ttm_top_test
`default_nettype wire
